/* dsc_instruction_decode_timing.sv */
`timescale 1ns/1ps
`default_nettype none
module dsc_instruction_decode_timing
    import dsc_decode_pkg::*;
(
    // Clock, reset and enable
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic              ce,
    // Program memory fetch path
    input  wire logic              fetch_valid,
    input  wire logic [INSN_W-1:0] fetch_word,
    output logic                   fetch_ready,
    output logic                   pc_redirect,
    // Datapath feedback
    input  wire logic              cond_true,
    input  wire logic [REG_W-1:0]  base_operand_value,
    input  wire logic              alu_update,
    input  wire logic              alu_sticky_z,
    input  wire status_t           alu_result,
    input  wire logic [1:0]        acc_update,
    input  wire logic [1:0]        acc_ov,
    input  wire logic [1:0]        acc_sat,
    // Issue to datapath
    output logic                   issue_valid,
    output logic                   issue_nop,
    output logic                   write_enable,
    output logic                   issue_two_word,
    output var  operands_t         issue_ops,
    // Status flags
    output var  status_t           status_flags,
    output var  dsp_status_t       dsp_flags
);
    // ---------------------------------------------------------------
    // Fetch-side decode
    // ---------------------------------------------------------------
    core_t             core_reg;
    core_t             core_next;
    operands_t         ops_dec;
    logic [INSN_W-1:0] word0_sel;
    logic [OPC_W-1:0]  opc;
    logic [OPC_W-1:0]  first_opc;
    logic              take;
    logic              is_two;
    logic              redirect;
    logic [1:0]        extra_cnt;

    assign opc         = fetch_word[OPC_LSB +: OPC_W];
    assign first_opc   = core_reg.first[OPC_LSB +: OPC_W];
    assign fetch_ready = ce && (core_reg.fsm != ST_EXTRA);
    assign take        = fetch_ready && fetch_valid;
    assign is_two      = (opc == OPC_ABS_JUMP) || (opc == OPC_ABS_CALL)
                      || (opc == OPC_LOOP);
    assign word0_sel   = (core_reg.fsm == ST_WORD2) ? core_reg.first : fetch_word;

    dsc_field_extract u_fields (
        .word0              (word0_sel),
        .word1              (fetch_word),
        .base_operand_value (base_operand_value),
        .ops                (ops_dec)
    );

    // ---------------------------------------------------------------
    // Cycle cost of single-word instructions
    // ---------------------------------------------------------------
    always_comb begin
        extra_cnt = 2'h0;
        redirect  = 1'h0;
        case (opc)
            OPC_RETURN, OPC_INT_EXIT: begin
                extra_cnt = 2'(RET_CYCLES - 1);
                redirect  = 1'h1;
            end
            OPC_UNCOND_JUMP, OPC_COMP_JUMP, OPC_IND_CALL, OPC_IND_JUMP: begin
                extra_cnt = 2'(FLOW_CYCLES - 1);
                redirect  = 1'h1;
            end
            OPC_TBL_RD, OPC_TBL_WR: begin
                extra_cnt = 2'(TBL_CYCLES - 1);
            end
            OPC_DMOVE: begin
                extra_cnt = 2'(DMOVE_CYCLES - 1);
            end
            OPC_COND_JUMP: begin
                if (cond_true) begin
                    extra_cnt = 2'(COND_CYCLES - 1);
                    redirect  = 1'h1;
                end
            end
            default: begin
                extra_cnt = 2'h0;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    always_comb begin
        core_next              = core_reg;
        core_next.issue_valid  = 1'h0;
        core_next.issue_nop    = 1'h0;
        core_next.write_enable = 1'h0;
        core_next.pc_redirect  = 1'h0;
        case (core_reg.fsm)
            ST_RUN: begin
                if (take && is_two) begin
                    core_next.first = fetch_word;
                    core_next.fsm   = ST_WORD2;
                end else if (take) begin
                    core_next.issue_valid  = 1'h1;
                    core_next.issue_nop    = (opc == OPC_NOP);
                    core_next.write_enable = (opc != OPC_NOP);
                    core_next.two_word     = 1'h0;
                    core_next.ops          = ops_dec;
                    core_next.pc_redirect  = redirect;
                    core_next.extra        = extra_cnt;
                    core_next.skip_second  = 1'h0;
                    if ((opc == OPC_SKIP) && cond_true) begin
                        core_next.fsm = ST_SKIP;
                    end else if (extra_cnt != 2'h0) begin
                        core_next.fsm = ST_EXTRA;
                    end
                end
            end
            ST_WORD2: begin
                if (take) begin
                    core_next.issue_valid  = 1'h1;
                    core_next.write_enable = 1'h1;
                    core_next.two_word     = 1'h1;
                    core_next.ops          = ops_dec;
                    core_next.pc_redirect  = (first_opc != OPC_LOOP);
                    core_next.fsm          = ST_RUN;
                end
            end
            ST_EXTRA: begin
                core_next.issue_valid = 1'h1;
                core_next.issue_nop   = 1'h1;
                core_next.extra       = core_reg.extra - 2'h1;
                if (core_reg.extra == 2'h1) begin
                    core_next.fsm = ST_RUN;
                end
            end
            ST_SKIP: begin
                if (take) begin
                    core_next.issue_valid = 1'h1;
                    core_next.issue_nop   = 1'h1;
                    if (is_two && !core_reg.skip_second) begin
                        core_next.skip_second = 1'h1;
                    end else begin
                        core_next.fsm = ST_RUN;
                    end
                end
            end
            default: begin
                core_next.fsm = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            core_reg <= '0;
        end else if (ce) begin
            core_reg <= core_next;
        end
    end

    // ---------------------------------------------------------------
    // Outputs and flags
    // ---------------------------------------------------------------
    assign issue_valid    = core_reg.issue_valid;
    assign issue_nop      = core_reg.issue_nop;
    assign write_enable   = core_reg.write_enable;
    assign issue_two_word = core_reg.two_word;
    assign issue_ops      = core_reg.ops;
    assign pc_redirect    = core_reg.pc_redirect;

    dsc_status_flags u_flags (
        .clk          (clk),
        .resetn       (resetn),
        .ce           (ce),
        .commit       (core_reg.write_enable),
        .alu_update   (alu_update),
        .alu_sticky_z (alu_sticky_z),
        .alu_result   (alu_result),
        .acc_update   (acc_update),
        .acc_ov       (acc_ov),
        .acc_sat      (acc_sat),
        .status_flags (status_flags),
        .dsp_flags    (dsp_flags)
    );

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    a_lone_second_word: assert property (@(posedge clk iff ce) disable iff (!resetn)
        (take && (core_reg.fsm == ST_RUN) && (opc == OPC_NOP))
        |=> issue_valid && issue_nop && !write_enable)
        else $error("lone second word not issued as no-op");

    a_cond_taken: assert property (@(posedge clk iff ce) disable iff (!resetn)
        (take && (core_reg.fsm == ST_RUN) && (opc == OPC_COND_JUMP) && cond_true)
        |=> (issue_valid && !issue_nop && pc_redirect && !fetch_ready)
        ##1 (issue_nop && fetch_ready))
        else $error("taken conditional did not take two cycles");

    a_return_three: assert property (@(posedge clk iff ce) disable iff (!resetn)
        (take && (core_reg.fsm == ST_RUN) && (opc == OPC_RETURN))
        |=> (issue_valid && !fetch_ready) ##1 (issue_nop && !fetch_ready)
        ##1 (issue_nop && fetch_ready))
        else $error("return did not take three cycles");

    a_skip_two_word: assert property (@(posedge clk iff ce) disable iff (!resetn)
        (take && (core_reg.fsm == ST_RUN) && (opc == OPC_SKIP) && cond_true)
        ##1 (take && is_two) |=> issue_nop && (core_reg.fsm == ST_SKIP))
        else $error("skip over two-word instruction ended early");

    a_two_word_pair: assert property (@(posedge clk iff ce) disable iff (!resetn)
        (take && (core_reg.fsm == ST_RUN) && is_two) ##1 take
        |=> issue_valid && issue_two_word && write_enable && !issue_nop)
        else $error("two-word instruction not issued on second word");

    a_dmove_two: assert property (@(posedge clk iff ce) disable iff (!resetn)
        (take && (core_reg.fsm == ST_RUN) && (opc == OPC_DMOVE))
        |=> (issue_ops.width == WIDTH_DOUBLE && !fetch_ready) ##1 (issue_nop && fetch_ready))
        else $error("double move did not take two cycles");

    a_byte_literal: assert property (@(posedge clk iff ce) disable iff (!resetn)
        (issue_valid && (issue_ops.width == WIDTH_BYTE)) |-> (issue_ops.ten_bit_literal < 10'h100))
        else $error("byte literal above 255");

    a_address_even: assert property (@(posedge clk iff ce) disable iff (!resetn)
        (issue_valid && issue_two_word) |-> !issue_ops.program_address_literal[0])
        else $error("program address literal is odd");

    a_nop_no_write: assert property (@(posedge clk iff ce) disable iff (!resetn)
        issue_nop |-> !write_enable ##1 (!issue_nop || !write_enable))
        else $error("write enabled during no-op cycle");
endmodule // dsc_instruction_decode_timing
`default_nettype wire

/* dsc_decode_pkg.sv */
// What this block does
// - Most instructions are one 24-bit program word.
// - Top 8 bits select the instruction type.
// - Three instructions span two words, 48 bits.
// - Second word alone executes as a no-op.
// - Taken condition or single-word redirect adds one no-op cycle; return adds two.
// - Branch, indirect, table, return take extra cycles.
// - Taken skip costs two or three cycles.
// - Double moves and two-word instructions take two.
// - Base, source, destination operand registers decoded.
// - File address plus result destination select.
// - File address spans zero through 0x1fff.
// - Bit chosen by 4-bit field or base.
// - Ten-bit literal limited to 255 in bytes.
// - Program address literal always has zero LSB.
// - Unsigned literals of 1,4,5,8,14,16 bits.
// - Signed literals are two's complement values.
// - Width select byte, word, double; shadow select.
// - Accumulator pick and write-back pointer modes.
// - Arithmetic updates carry flags; zero is sticky.
// - Per-accumulator overflow and clamp flags reported.
`default_nettype none
package dsc_decode_pkg;
    // ---------------------------------------------------------------
    // Word and field layout
    // ---------------------------------------------------------------
    localparam int INSN_W     = 24;
    localparam int OPC_W      = 8;
    localparam int OPC_LSB    = 16;
    localparam int REG_W      = 4;
    localparam int MODE_W     = 3;
    localparam int SRC_LSB    = 0;
    localparam int SMODE_LSB  = 4;
    localparam int DST_LSB    = 7;
    localparam int DMODE_LSB  = 11;
    localparam int BASE_LSB   = 12;
    localparam int BYTE_BIT   = 14;
    localparam int SHADOW_BIT = 15;
    localparam int FILE_W     = 13;
    localparam int FILE_LSB   = 0;
    localparam int FDEST_BIT  = 13;
    localparam logic [FILE_W-1:0] FILE_ADDR_MAX = 13'h1fff;
    localparam int BITPOS_W   = 4;
    localparam int BITPOS_LSB = 12;
    localparam int BITIND_BIT = 11;
    localparam int L10_W      = 10;
    localparam int L10_LSB    = 4;
    localparam int BYTE_LIT_W = 8;
    localparam int LIT_N      = 6;
    localparam int LIT_MAX_W  = 16;
    localparam int LIT_WIDTHS [LIT_N] = '{1, 4, 5, 8, 14, 16};
    localparam int ACC_BIT    = 15;
    localparam int AWB_LSB    = 13;
    localparam int AWB_W      = 2;
    localparam logic [REG_W-1:0] AWB_REG = 4'hd;
    localparam int AWB_STEP   = 2;
    localparam int PAL_W      = 23;
    localparam int PAL_HI_W   = 7;
    localparam int PAL_LO_LSB = 1;
    localparam int PAL_LO_W   = 15;
    // ---------------------------------------------------------------
    // Opcodes and cycle counts
    // ---------------------------------------------------------------
    localparam logic [OPC_W-1:0] OPC_NOP         = 8'h00;
    localparam logic [OPC_W-1:0] OPC_ABS_CALL    = 8'h02;
    localparam logic [OPC_W-1:0] OPC_ABS_JUMP    = 8'h04;
    localparam logic [OPC_W-1:0] OPC_LOOP        = 8'h08;
    localparam logic [OPC_W-1:0] OPC_COMP_JUMP   = 8'h01;
    localparam logic [OPC_W-1:0] OPC_IND_CALL    = 8'h03;
    localparam logic [OPC_W-1:0] OPC_IND_JUMP    = 8'h05;
    localparam logic [OPC_W-1:0] OPC_RETURN      = 8'h06;
    localparam logic [OPC_W-1:0] OPC_INT_EXIT    = 8'h07;
    localparam logic [OPC_W-1:0] OPC_COND_JUMP   = 8'h31;
    localparam logic [OPC_W-1:0] OPC_UNCOND_JUMP = 8'h37;
    localparam logic [OPC_W-1:0] OPC_SKIP        = 8'ha6;
    localparam logic [OPC_W-1:0] OPC_TBL_RD      = 8'hba;
    localparam logic [OPC_W-1:0] OPC_TBL_WR      = 8'hbb;
    localparam logic [OPC_W-1:0] OPC_DMOVE       = 8'hbe;
    localparam int RET_CYCLES   = 3;
    localparam int FLOW_CYCLES  = 2;
    localparam int TBL_CYCLES   = 2;
    localparam int DMOVE_CYCLES = 2;
    localparam int COND_CYCLES  = 2;
    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {WIDTH_WORD, WIDTH_BYTE, WIDTH_DOUBLE} width_t;
    typedef enum logic [1:0] {AWB_NONE, AWB_DIRECT, AWB_POSTINC} awb_t;
    typedef enum logic [1:0] {ST_RUN, ST_WORD2, ST_EXTRA, ST_SKIP} fsm_t;
    typedef struct packed {
        logic [OPC_W-1:0]                 opcode;
        width_t                           width;
        logic                             shadow;
        logic [REG_W-1:0]                 base_operand_reg;
        logic [REG_W-1:0]                 source_operand_reg;
        logic [MODE_W-1:0]                source_mode;
        logic [REG_W-1:0]                 dest_operand_reg;
        logic [MODE_W-1:0]                dest_mode;
        logic [FILE_W-1:0]                file_addr;
        logic                             dest_default_work_reg0;
        logic                             bit_indirect;
        logic [BITPOS_W-1:0]              bit_position_field;
        logic [L10_W-1:0]                 ten_bit_literal;
        logic [LIT_MAX_W-1:0]             signed_ten_bit_literal;
        logic [LIT_N-1:0][LIT_MAX_W-1:0]  unsigned_lit;
        logic                             acc_sel;
        awb_t                             acc_writeback_ptr;
        logic [REG_W-1:0]                 acc_writeback_reg;
        logic [PAL_W-1:0]                 program_address_literal;
    } operands_t;
    typedef struct packed {
        logic carry;
        logic digit_carry_flag;
        logic negative;
        logic overflow;
        logic zero;
    } status_t;
    typedef struct packed {
        logic acc_a_overflowed;
        logic acc_b_overflowed;
        logic acc_a_clamped;
        logic acc_b_clamped;
    } dsp_status_t;
    typedef struct packed {
        status_t     mcu;
        dsp_status_t dsp;
    } flags_t;
    typedef struct packed {
        fsm_t              fsm;
        logic [1:0]        extra;
        logic              skip_second;
        logic [INSN_W-1:0] first;
        logic              issue_valid;
        logic              issue_nop;
        logic              write_enable;
        logic              two_word;
        logic              pc_redirect;
        operands_t         ops;
    } core_t;
endpackage
`default_nettype wire

/* dsc_field_extract.sv */
`timescale 1ns/1ps
`default_nettype none
module dsc_field_extract
    import dsc_decode_pkg::*;
(
    // Instruction words
    input  wire logic [INSN_W-1:0] word0,
    input  wire logic [INSN_W-1:0] word1,
    // Datapath operand
    input  wire logic [REG_W-1:0]  base_operand_value,
    // Decoded fields
    output var  operands_t         ops
);
    logic [LIT_N-1:0][LIT_MAX_W-1:0] lit_u;

    for (genvar i = 0; i < LIT_N; i++) begin : g_lit
        assign lit_u[i] = LIT_MAX_W'(word0[LIT_WIDTHS[i]-1:0]);
    end

    always_comb begin
        ops                    = '0;
        ops.opcode             = word0[OPC_LSB +: OPC_W];
        if (ops.opcode == OPC_DMOVE) begin
            ops.width = WIDTH_DOUBLE;
        end else if (word0[BYTE_BIT]) begin
            ops.width = WIDTH_BYTE;
        end else begin
            ops.width = WIDTH_WORD;
        end
        ops.shadow             = word0[SHADOW_BIT];
        ops.base_operand_reg   = word0[BASE_LSB +: REG_W];
        ops.source_operand_reg = word0[SRC_LSB +: REG_W];
        ops.source_mode        = word0[SMODE_LSB +: MODE_W];
        ops.dest_operand_reg   = word0[DST_LSB +: REG_W];
        ops.dest_mode          = word0[DMODE_LSB +: MODE_W];
        ops.file_addr          = word0[FILE_LSB +: FILE_W];
        ops.dest_default_work_reg0 = !word0[FDEST_BIT];
        ops.bit_indirect       = word0[BITIND_BIT];
        if (word0[BITIND_BIT]) begin
            ops.bit_position_field = base_operand_value;
        end else begin
            ops.bit_position_field = word0[BITPOS_LSB +: BITPOS_W];
        end
        if (word0[BYTE_BIT]) begin
            ops.ten_bit_literal = {2'h0, word0[L10_LSB +: BYTE_LIT_W]};
        end else begin
            ops.ten_bit_literal = word0[L10_LSB +: L10_W];
        end
        ops.signed_ten_bit_literal = {{(LIT_MAX_W-L10_W){word0[L10_LSB+L10_W-1]}},
                                      word0[L10_LSB +: L10_W]};
        ops.unsigned_lit       = lit_u;
        ops.acc_sel            = word0[ACC_BIT];
        ops.acc_writeback_reg  = AWB_REG;
        case (word0[AWB_LSB +: AWB_W])
            2'h1:    ops.acc_writeback_ptr = AWB_DIRECT;
            2'h2:    ops.acc_writeback_ptr = AWB_POSTINC;
            default: ops.acc_writeback_ptr = AWB_NONE;
        endcase
        ops.program_address_literal = {word1[PAL_HI_W-1:0],
                                       word0[PAL_LO_LSB +: PAL_LO_W], 1'h0};
    end
endmodule // dsc_field_extract
`default_nettype wire

/* dsc_status_flags.sv */
`timescale 1ns/1ps
`default_nettype none
module dsc_status_flags
    import dsc_decode_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    // Result reports
    input  wire logic        commit,
    input  wire logic        alu_update,
    input  wire logic        alu_sticky_z,
    input  wire status_t     alu_result,
    input  wire logic [1:0]  acc_update,
    input  wire logic [1:0]  acc_ov,
    input  wire logic [1:0]  acc_sat,
    // Flags
    output var  status_t     status_flags,
    output var  dsp_status_t dsp_flags
);
    flags_t flags_reg;
    flags_t flags_next;

    always_comb begin
        flags_next = flags_reg;
        if (commit && alu_update) begin
            flags_next.mcu = alu_result;
            if (alu_sticky_z) begin
                flags_next.mcu.zero = flags_reg.mcu.zero & alu_result.zero;
            end
        end
        if (commit && acc_update[0]) begin
            flags_next.dsp.acc_a_overflowed = acc_ov[0];
            flags_next.dsp.acc_a_clamped    = acc_sat[0];
        end
        if (commit && acc_update[1]) begin
            flags_next.dsp.acc_b_overflowed = acc_ov[1];
            flags_next.dsp.acc_b_clamped    = acc_sat[1];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            flags_reg <= '0;
        end else if (ce) begin
            flags_reg <= flags_next;
        end
    end

    assign status_flags = flags_reg.mcu;
    assign dsp_flags    = flags_reg.dsp;

    a_sticky_zero: assert property (@(posedge clk iff ce) disable iff (!resetn)
        (commit && alu_update && alu_sticky_z && !status_flags.zero) |=> !status_flags.zero)
        else $error("sticky zero flag was set again");
    a_acc_b_flags: assert property (@(posedge clk iff ce) disable iff (!resetn)
        (commit && acc_update[1]) |=> (dsp_flags.acc_b_overflowed == $past(acc_ov[1]))
        && (dsp_flags.acc_b_clamped == $past(acc_sat[1])))
        else $error("accumulator b flags not updated");
    a_no_commit: assert property (@(posedge clk iff ce) disable iff (!resetn)
        !commit |=> $stable(status_flags) && $stable(dsp_flags))
        else $error("flags changed without commit");
endmodule // dsc_status_flags
`default_nettype wire

/* dsc_prog_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dsc_prog_mem_model
    import dsc_decode_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              resetn,
    // Fetch path
    input  wire logic              fetch_ready,
    output logic                   fetch_valid,
    output logic [INSN_W-1:0]      fetch_word,
    // Datapath feedback
    output logic                   cond_true,
    output logic                   alu_update,
    output logic                   alu_sticky_z,
    output status_t                alu_result
);
    localparam int N = 10;
    // Each entry is the condition answer and the program word.
    logic [INSN_W:0] prog [N] = '{25'h0a60000, 25'h0060000, 25'h0370000,
        25'h0040246, 25'h0000035, 25'h0be0000, 25'h1a60000, 25'h0020000,
        25'h0000000, 25'h0000000}; // Second words keep their top byte at zero.
    int   idx  = 0;
    logic took = 1'b0;
    initial begin
        fetch_valid  = 1'b0;
        fetch_word   = 24'h000000;
        cond_true    = 1'b0;
        {alu_update, alu_sticky_z, alu_result} = 7'h00;
    end
    always @(posedge clk) begin
        took <= fetch_valid && fetch_ready;
    end
    // Words advance on a take; a released line shows the inverse of its last value.
    always @(negedge clk) begin
        if (took) idx = idx + 1;
        fetch_valid  = resetn && idx < N;
        fetch_word   = fetch_valid ? prog[idx][INSN_W-1:0] : ~fetch_word;
        cond_true    = fetch_valid ? prog[idx][INSN_W] : ~cond_true;
        alu_update   = fetch_word[0];
        alu_sticky_z = fetch_word[1];
        alu_result   = status_t'(fetch_word[6:2]);
    end
endmodule // dsc_prog_mem_model
`default_nettype wire

/* dsc_instruction_decode_timing_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module dsc_instruction_decode_timing_tb_top;
    import dsc_decode_pkg::*;
    logic              clk, resetn, fetch_valid, fetch_ready, pc_redirect, cond_true;
    logic              alu_update, alu_sticky_z, issue_valid, issue_nop;
    logic              write_enable, issue_two_word;
    logic [INSN_W-1:0] fetch_word;
    status_t           alu_result, status_flags;
    dsp_status_t       dsp_flags;
    operands_t         issue_ops;
    int                n_errors  = 0;
    int                cmp_count = 0;
    logic [1:0]        seen [$];
    // Issue events as {nop, redirect}, in program order.
    logic [1:0]        want [13] = '{0, 1, 2, 2, 1, 2, 1, 0, 2, 0, 2, 2, 2};
    dsc_prog_mem_model dsc_prog_mem_model_i (.clk(clk), .resetn(resetn),
        .fetch_ready(fetch_ready), .fetch_valid(fetch_valid), .fetch_word(fetch_word),
        .cond_true(cond_true), .alu_update(alu_update), .alu_sticky_z(alu_sticky_z),
        .alu_result(alu_result));
    dsc_instruction_decode_timing dsc_instruction_decode_timing_i (.clk(clk),
        .resetn(resetn), .ce(1'b1), .fetch_valid(fetch_valid), .fetch_word(fetch_word),
        .fetch_ready(fetch_ready), .pc_redirect(pc_redirect), .cond_true(cond_true),
        .base_operand_value(4'h0), .alu_update(alu_update), .alu_sticky_z(alu_sticky_z),
        .alu_result(alu_result), .acc_update(2'h0), .acc_ov(2'h0), .acc_sat(2'h0),
        .issue_valid(issue_valid), .issue_nop(issue_nop), .write_enable(write_enable),
        .issue_two_word(issue_two_word), .issue_ops(issue_ops),
        .status_flags(status_flags), .dsp_flags(dsp_flags));
    task automatic check(logic [31:0] got, logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        if (n_errors == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Collects every issue and checks what travels with it.
    always @(negedge clk) begin
        if (issue_valid === 1'b1) begin
            seen.push_back({issue_nop, pc_redirect});
            if (issue_nop === 1'b1) check(write_enable, 0);
            if (issue_two_word === 1'b1 && issue_nop !== 1'b1)
                check(issue_ops.program_address_literal, 23'h350246);
        end
    end
    initial begin
        resetn = 1'b0;
        repeat (20) @(negedge clk);
        check(issue_valid, 0);
        resetn <= 1'b1;
        for (int i = 0; i < 200 && seen.size() < 13; i++) @(negedge clk);
        repeat (5) @(negedge clk);
        check(seen.size(), 13);
        foreach (want[i]) check(seen[i], want[i]);
        check(dsp_flags, 0);
        check(status_flags, 0);
        finish_test();
    end
endmodule // dsc_instruction_decode_timing_tb_top
`default_nettype wire
